// ===== common/ubf_pkg.sv
package ubf_pkg;
   // register byte addresses on the mcu bus
   localparam logic [15:0] ADDR_MODEM_CTRL = 16'hffa4;
   localparam logic [15:0] ADDR_FLOW_CTRL  = 16'hffa5;
   localparam logic [15:0] ADDR_DIV_LOW    = 16'hffa7;
   localparam logic [15:0] ADDR_DIV_HIGH   = 16'hffa8;
   localparam logic [15:0] ADDR_RESUME     = 16'hffa9;
   localparam logic [15:0] ADDR_PAUSE      = 16'hffaa;
   localparam logic [15:0] ADDR_IRQ_EN     = 16'hffab;
   localparam logic [15:0] ADDR_STATUS     = 16'hffac;
   localparam logic [15:0] ADDR_RX_LEVEL   = 16'hffad;
   localparam logic [15:0] ADDR_DMA_CTRL   = 16'hffae;

   // reset values
   localparam logic [7:0] RST_DIV_LOW   = 8'h08;
   localparam logic [7:0] RST_DIV_HIGH  = 8'h00;
   localparam logic [7:0] RST_RESUME    = 8'h00;
   localparam logic [7:0] RST_PAUSE     = 8'h00;
   localparam logic [2:0] RST_IRQ_EN    = 3'h0;
   localparam logic [7:0] RST_MODEM     = 8'h00;
   localparam logic [3:0] RST_FLOW      = 4'h0;
   localparam logic [7:0] RST_DMA_CTRL  = 8'h00;

   // interrupt-enable bit positions
   localparam int IE_MODEM  = 0;
   localparam int IE_STATUS = 1;
   localparam int IE_TXRX   = 2;

   // flow-control register bit positions
   localparam int FC_AUTO_CTS = 0;
   localparam int FC_AUTO_RTS = 1;
   localparam int FC_XON_RX   = 2;
   localparam int FC_XON_TX   = 3;

   // modem control and dma control bit positions
   localparam int MC_XON_SEL    = 5;
   localparam int DMA_CONT_BIT  = 5;

   // status bit positions
   localparam int ST_RESUME_HIT = 0;
   localparam int ST_PAUSE_HIT  = 1;
   localparam int ST_RX_OVF     = 2;
   localparam int ST_RTS        = 3;
   localparam int ST_TX_PAUSED  = 4;
   localparam int ST_DMA_HALF   = 5;
   localparam int ST_CTS_HOLD   = 6;

   // receive fifo marks
   localparam int RX_DEPTH     = 32;
   localparam int RX_HALT_MARK = 12;
   localparam int RX_RES_MARK  = 4;

   // buffer memory
   localparam int BUF_BYTES  = 512;
   localparam int DBUF_BYTES = 64;

   // reference divider: 6.5 = 13 master cycles per two ticks
   localparam int REF_DIV_X2    = 13;
   localparam int REF_FIRST_HOP = 6;
   localparam int OVERSAMPLE    = 16;
endpackage

// ===== common/ubf_baud_if.sv
interface ubf_baud_if;
   logic [15:0] divisor;
   logic        sample_tick;
   logic        bit_tick;
   logic        ref_tick;

   modport gen  (input divisor, output sample_tick, bit_tick, ref_tick);
   modport user (output divisor, input sample_tick, bit_tick, ref_tick);
endinterface

// ===== hdl/ubf_baud_gen.sv
module ubf_baud_gen
   import ubf_pkg::*;
(
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic rst_i,
   // divisor in, ticks out
   ubf_baud_if.gen   baud
);
   logic [3:0]  phase_q;
   logic [15:0] div_cnt_q;
   logic [3:0]  over_cnt_q;
   logic        ref_q;
   logic        samp_q;
   logic        bit_q;

   wire phase_wrap = (phase_q == 4'(REF_DIV_X2 - 1));
   wire ref_now    = phase_wrap || (phase_q == 4'(REF_FIRST_HOP - 1));
   wire div_wrap   = (div_cnt_q == 16'h0000);
   wire samp_now   = ref_now && div_wrap;
   wire over_wrap  = (over_cnt_q == 4'(OVERSAMPLE - 1));

   // alternating 6 and 7 cycle hops average 6.5
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         phase_q <= 4'h0;
      end else begin
         phase_q <= phase_wrap ? 4'h0 : phase_q + 4'h1; // [R3]
      end
   end

   // divisor 0 counts 65536 ref ticks
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         div_cnt_q <= 16'h0000;
      end else if (ref_now) begin
         div_cnt_q <= div_wrap ? baud.divisor - 16'h0001 : div_cnt_q - 16'h0001; // [R4]
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         over_cnt_q <= 4'h0;
      end else if (samp_now) begin
         over_cnt_q <= over_wrap ? 4'h0 : over_cnt_q + 4'h1; // [R4]
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ref_q  <= 1'b0;
         samp_q <= 1'b0;
         bit_q  <= 1'b0;
      end else begin
         ref_q  <= ref_now;
         samp_q <= samp_now;
         bit_q  <= samp_now && over_wrap; // [R5]
      end
   end

   assign baud.ref_tick    = ref_q;
   assign baud.sample_tick = samp_q;
   assign baud.bit_tick    = bit_q;
endmodule

// ===== hdl/ubf_top.sv
// How it works
// [R1] divisor high byte register, resets zero
// [R2] divisor low byte register, resets eight
// [R3] reference tick is master clock over 6.5
// [R4] reference divided by divisor, then sixteen
// [R5] divisor 8 or 1 gives documented rates
// [R6] resume match flags, interrupts when enabled
// [R7] pause match halts dma, interrupts when enabled
// [R8] flow characters sent use programmed values
// [R9] enable bits: modem, status, tx/rx
// [R10] enable bits 7..3 read as zero
// [R11] channel buffer with 64-byte x/y space
// [R12] dma and buffer manager use opposite halves
// [R13] firmware sets continuous bit for auto toggle
// [R14] receive fifo holds 32 bytes
// [R15] fixed marks at 12 and 4 bytes
// [R16] auto rts high at 12, low at 4
// [R17] between marks, rts and last character hold
// [R18] auto cts high suspends transmit dma
// [R19] cts, rts, xon/xoff enabled separately
// [R20] firmware selects xon/xoff via modem control
// [R21] pause sent at 12, resume sent at 4
// [R22] pause match stops tx dma, resume restarts
// [R23] mcu swaps only when y empty, x full
module ubf_top
   import ubf_pkg::*;
#(
   parameter int RX_DEPTH_P = ubf_pkg::RX_DEPTH,
   parameter int HALF_BYTES = ubf_pkg::DBUF_BYTES / 2
) (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   // register port
   input  wire logic [15:0] reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [7:0]  reg_rdata_o,
   // uart receiver byte in
   input  wire logic [7:0]  rx_byte_i,
   input  wire logic        rx_byte_valid_i,
   // receive dma
   input  wire logic        rx_dma_rd_i,
   output logic      [7:0]  rx_dma_data_o,
   output logic             rx_dma_avail_o,
   // buffer manager fills transmit halves
   input  wire logic [7:0]  ubm_wdata_i,
   input  wire logic        ubm_wr_i,
   output logic             ubm_ready_o,
   // transmit data register feed
   input  wire logic        tdr_ready_i,
   output logic      [7:0]  tdr_data_o,
   output logic             tdr_load_o,
   // flow-control character send
   input  wire logic        fc_tx_ready_i,
   output logic      [7:0]  fc_tx_char_o,
   output logic             fc_tx_valid_o,
   // modem lines
   input  wire logic        cts_i,
   output logic             rts_o,
   // baud ticks and interrupt
   output logic             sample_tick_o,
   output logic             bit_tick_o,
   output logic             irq_o
);
   localparam int CW = $clog2(RX_DEPTH_P + 1);
   localparam int PW = $clog2(RX_DEPTH_P);
   localparam int HW = $clog2(HALF_BYTES);
   localparam int LW = $clog2(HALF_BYTES + 1);

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] div_low_q, div_high_q, resume_q, pause_q;
   logic [2:0] irq_en_q;
   logic [7:0] modem_q;
   logic [3:0] flow_q;
   logic [7:0] dma_ctrl_q;
   logic [2:0] flags_q;
   logic [2:0] flags_d;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
      return a == r;
   endfunction

   wire wr_div_low  = reg_wr_i && hit(reg_addr_i, ADDR_DIV_LOW);
   wire wr_div_high = reg_wr_i && hit(reg_addr_i, ADDR_DIV_HIGH);
   wire wr_resume   = reg_wr_i && hit(reg_addr_i, ADDR_RESUME);
   wire wr_pause    = reg_wr_i && hit(reg_addr_i, ADDR_PAUSE);
   wire wr_irq_en   = reg_wr_i && hit(reg_addr_i, ADDR_IRQ_EN);
   wire wr_modem    = reg_wr_i && hit(reg_addr_i, ADDR_MODEM_CTRL);
   wire wr_flow     = reg_wr_i && hit(reg_addr_i, ADDR_FLOW_CTRL);
   wire wr_dma      = reg_wr_i && hit(reg_addr_i, ADDR_DMA_CTRL);
   wire wr_status   = reg_wr_i && hit(reg_addr_i, ADDR_STATUS);

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         div_low_q  <= RST_DIV_LOW; // [R2]
         div_high_q <= RST_DIV_HIGH; // [R1]
         resume_q   <= RST_RESUME;
         pause_q    <= RST_PAUSE;
         irq_en_q   <= RST_IRQ_EN; // [R9]
         modem_q    <= RST_MODEM;
         flow_q     <= RST_FLOW;
         dma_ctrl_q <= RST_DMA_CTRL;
      end else begin
         if (wr_div_low)  div_low_q  <= reg_wdata_i; // [R2]
         if (wr_div_high) div_high_q <= reg_wdata_i; // [R1]
         if (wr_resume)   resume_q   <= reg_wdata_i;
         if (wr_pause)    pause_q    <= reg_wdata_i;
         if (wr_irq_en)   irq_en_q   <= reg_wdata_i[2:0]; // [R9]
         if (wr_modem)    modem_q    <= reg_wdata_i;
         if (wr_flow)     flow_q     <= reg_wdata_i[3:0]; // [R19]
         if (wr_dma)      dma_ctrl_q <= reg_wdata_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mode decode
   wire xon_sel    = modem_q[MC_XON_SEL] && (modem_q[7:6] == 2'b00);
   wire auto_cts   = flow_q[FC_AUTO_CTS]; // [R19]
   wire auto_rts   = flow_q[FC_AUTO_RTS]; // [R19]
   wire xon_rx_en  = flow_q[FC_XON_RX] && xon_sel; // [R19]
   wire xon_tx_en  = flow_q[FC_XON_TX] && xon_sel; // [R19]
   wire cont_mode  = dma_ctrl_q[DMA_CONT_BIT]; // [R13]

   ////////////////////////////////////////////////////////////////////////
   // baud generator
   ubf_baud_if baud ();
   assign baud.divisor = {div_high_q, div_low_q}; // [R4]

   ubf_baud_gen u_baud (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .baud   (baud.gen)
   );

   ////////////////////////////////////////////////////////////////////////
   // receive fifo
   logic [7:0]    rx_mem [RX_DEPTH_P]; // [R14]
   logic [PW-1:0] rx_wp_q, rx_rp_q;
   logic [CW-1:0] rx_cnt_q;
   logic [7:0]    rx_out_q;
   logic          rx_avail_q;

   wire rx_full  = (rx_cnt_q == CW'(RX_DEPTH_P));
   wire rx_empty = (rx_cnt_q == '0);
   wire rx_push  = rx_byte_valid_i && !rx_full; // [R14]
   wire rx_pop   = rx_dma_rd_i && !rx_empty;
   wire rx_ovf   = rx_byte_valid_i && rx_full;
   wire [CW-1:0] rx_cnt_d = rx_cnt_q + CW'(rx_push) - CW'(rx_pop);
   wire at_halt  = (rx_cnt_d >= CW'(RX_HALT_MARK)); // [R15]
   wire at_res   = (rx_cnt_d <= CW'(RX_RES_MARK)); // [R15]

   always_ff @(posedge mclk_i) begin
      if (rx_push) rx_mem[rx_wp_q] <= rx_byte_i;
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rx_wp_q    <= '0;
         rx_rp_q    <= '0;
         rx_cnt_q   <= '0;
         rx_out_q   <= 8'h00;
         rx_avail_q <= 1'b0;
      end else begin
         if (rx_push) rx_wp_q <= PW'(rx_wp_q + 1'b1);
         if (rx_pop) rx_rp_q <= PW'(rx_rp_q + 1'b1);
         if (rx_pop) rx_out_q <= rx_mem[rx_rp_q];
         rx_cnt_q   <= rx_cnt_d;
         rx_avail_q <= (rx_cnt_d != '0);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // character match on received bytes
   wire resume_hit = rx_byte_valid_i && (rx_byte_i == resume_q); // [R6]
   wire pause_hit  = rx_byte_valid_i && (rx_byte_i == pause_q); // [R7]

   // set wins over write-one-to-clear
   assign flags_d = (flags_q & ~(wr_status ? reg_wdata_i[2:0] : 3'h0))
                  | {rx_ovf, pause_hit, resume_hit}; // [R6] [R7]

   logic tx_paused_q;
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         flags_q     <= 3'h0;
         tx_paused_q <= 1'b0;
      end else begin
         flags_q <= flags_d;
         if (!xon_tx_en) tx_paused_q <= 1'b0;
         else if (pause_hit) tx_paused_q <= 1'b1; // [R7] [R22]
         else if (resume_hit) tx_paused_q <= 1'b0; // [R22]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receive flow control: rts and pause/resume characters
   logic rts_q;
   logic paused_sent_q;
   logic fc_valid_q;
   logic [7:0] fc_char_q;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rts_q <= 1'b0;
      end else if (!auto_rts) begin
         rts_q <= 1'b0;
      end else if (at_halt) begin
         rts_q <= 1'b1; // [R16]
      end else if (at_res) begin
         rts_q <= 1'b0; // [R16]
      end // [R17]
   end

   wire fc_busy   = fc_valid_q && !fc_tx_ready_i;
   wire want_off  = xon_rx_en && at_halt && !paused_sent_q; // [R21]
   wire want_on   = xon_rx_en && at_res && paused_sent_q; // [R21]

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         paused_sent_q <= 1'b0;
         fc_valid_q    <= 1'b0;
         fc_char_q     <= 8'h00;
      end else if (!fc_busy) begin
         fc_valid_q <= want_off || want_on;
         if (want_off) begin
            fc_char_q     <= pause_q; // [R8]
            paused_sent_q <= 1'b1;
         end else if (want_on) begin
            fc_char_q     <= resume_q; // [R8]
            paused_sent_q <= 1'b0;
         end else if (!xon_rx_en) begin
            paused_sent_q <= 1'b0;
         end // [R17]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit x/y double buffer
   logic [7:0]    dbuf [2][HALF_BYTES]; // [R11]
   logic          dma_half_q;
   logic [HW-1:0] dma_rp_q, ubm_wp_q;
   logic [LW-1:0] dma_left_q, ubm_fill_q;
   logic [7:0]    tdr_q;
   logic          tdr_load_q;
   logic          ubm_ready_q;

   wire ubm_half   = !dma_half_q; // [R12]
   wire ubm_full   = (ubm_fill_q == LW'(HALF_BYTES));
   wire ubm_push   = ubm_wr_i && !ubm_full;
   wire dma_empty  = (dma_left_q == '0);
   wire cts_hold   = auto_cts && cts_i; // [R18]
   wire tx_go      = !cts_hold && !tx_paused_q; // [R18] [R22]
   wire dma_pop    = tdr_ready_i && tx_go && !dma_empty && !tdr_load_q;
   // halves trade only when dma side drained and other side full
   wire swap       = cont_mode && dma_empty && ubm_full; // [R12] [R23]

   always_ff @(posedge mclk_i) begin
      if (ubm_push) dbuf[ubm_half][ubm_wp_q] <= ubm_wdata_i;
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         dma_half_q <= 1'b0;
         dma_rp_q   <= '0;
         ubm_wp_q   <= '0;
         dma_left_q <= '0;
         ubm_fill_q <= '0;
      end else if (swap) begin
         dma_half_q <= !dma_half_q; // [R12]
         dma_rp_q   <= '0;
         ubm_wp_q   <= '0;
         dma_left_q <= ubm_fill_q;
         ubm_fill_q <= '0;
      end else begin
         if (ubm_push) begin
            ubm_wp_q   <= HW'(ubm_wp_q + 1'b1);
            ubm_fill_q <= LW'(ubm_fill_q + 1'b1);
         end
         if (dma_pop) begin
            dma_rp_q   <= HW'(dma_rp_q + 1'b1);
            dma_left_q <= LW'(dma_left_q - 1'b1);
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         tdr_q       <= 8'h00;
         tdr_load_q  <= 1'b0;
         ubm_ready_q <= 1'b0;
      end else begin
         tdr_load_q  <= dma_pop; // [R18]
         if (dma_pop) tdr_q <= dbuf[dma_half_q][dma_rp_q];
         ubm_ready_q <= !swap && (ubm_fill_q + LW'(ubm_push) < LW'(HALF_BYTES));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data and interrupt
   logic [7:0] rdata_q;
   logic       irq_q;
   logic [7:0] status_w;

   assign status_w = {1'b0, cts_hold, dma_half_q, tx_paused_q, rts_q, flags_q};

   wire [7:0] rd_mux =
        hit(reg_addr_i, ADDR_DIV_LOW)    ? div_low_q :
        hit(reg_addr_i, ADDR_DIV_HIGH)   ? div_high_q :
        hit(reg_addr_i, ADDR_RESUME)     ? resume_q :
        hit(reg_addr_i, ADDR_PAUSE)      ? pause_q :
        hit(reg_addr_i, ADDR_IRQ_EN)     ? {5'h00, irq_en_q} : // [R10]
        hit(reg_addr_i, ADDR_MODEM_CTRL) ? modem_q :
        hit(reg_addr_i, ADDR_FLOW_CTRL)  ? {4'h0, flow_q} :
        hit(reg_addr_i, ADDR_DMA_CTRL)   ? dma_ctrl_q :
        hit(reg_addr_i, ADDR_STATUS)     ? status_w :
        hit(reg_addr_i, ADDR_RX_LEVEL)   ? 8'(rx_cnt_q) :
                                           8'h00;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_q <= 8'h00;
         irq_q   <= 1'b0;
      end else begin
         rdata_q <= reg_rd_i ? rd_mux : 8'h00;
         irq_q   <= irq_en_q[IE_STATUS] && (|flags_d); // [R6] [R7]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   logic samp_q, bitt_q;
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         samp_q <= 1'b0;
         bitt_q <= 1'b0;
      end else begin
         samp_q <= baud.sample_tick;
         bitt_q <= baud.bit_tick; // [R5]
      end
   end

   assign reg_rdata_o    = rdata_q;
   assign rx_dma_data_o  = rx_out_q;
   assign rx_dma_avail_o = rx_avail_q;
   assign ubm_ready_o    = ubm_ready_q;
   assign tdr_data_o     = tdr_q;
   assign tdr_load_o     = tdr_load_q;
   assign fc_tx_char_o   = fc_char_q;
   assign fc_tx_valid_o  = fc_valid_q;
   assign rts_o          = rts_q;
   assign sample_tick_o  = samp_q;
   assign bit_tick_o     = bitt_q;
   assign irq_o          = irq_q;
endmodule

// ===== verification/ubf_top_monitor.sv
module ubf_top_monitor
   import ubf_pkg::*;
(
   // clock and reset
   input wire logic        mclk_i,
   input wire logic        rst_i,
   // register port
   input wire logic [15:0] reg_addr_i,
   input wire logic [7:0]  reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [7:0]  reg_rdata_o,
   // receive, transmit, flow
   input wire logic [7:0]  rx_byte_i,
   input wire logic        rx_byte_valid_i,
   input wire logic        tdr_load_o,
   input wire logic        fc_tx_ready_i,
   input wire logic [7:0]  fc_tx_char_o,
   input wire logic        fc_tx_valid_o,
   input wire logic        cts_i,
   input wire logic        irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] res_q;
   logic [7:0] pau_q;
   logic [7:0] fc_q;
   logic [2:0] ie_q;
   logic       hit;

   assign hit = rx_byte_i == res_q || rx_byte_i == pau_q;

   // shadow of the registers the checks depend on
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         res_q <= RST_RESUME;
         pau_q <= RST_PAUSE;
         fc_q  <= 8'h00;
         ie_q  <= RST_IRQ_EN;
      end else if (reg_wr_i) begin
         if (reg_addr_i == ADDR_RESUME) res_q <= reg_wdata_i;
         if (reg_addr_i == ADDR_PAUSE) pau_q <= reg_wdata_i;
         if (reg_addr_i == ADDR_FLOW_CTRL) fc_q <= reg_wdata_i;
         if (reg_addr_i == ADDR_IRQ_EN) ie_q <= reg_wdata_i[2:0];
      end
   end

   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   sequence s_cts_held;
      (fc_q[FC_AUTO_CTS] && cts_i) [*3];
   endsequence
   sequence s_match;
      rx_byte_valid_i && ie_q[IE_STATUS] && hit;
   endsequence

   property p_rd_idle;
      !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
   endproperty
   property p_ie_read;
      reg_rd_i && reg_addr_i == ADDR_IRQ_EN |=> reg_rdata_o == {5'h00, ie_q};
   endproperty
   property p_fc_hold;
      fc_tx_valid_o && !fc_tx_ready_i |=> fc_tx_valid_o && $stable(fc_tx_char_o);
   endproperty
   property p_fc_char;
      fc_tx_valid_o |-> fc_tx_char_o == res_q || fc_tx_char_o == pau_q;
   endproperty
   property p_load_gap;
      tdr_load_o |=> !tdr_load_o;
   endproperty
   property p_cts_stop;
      s_cts_held |-> !tdr_load_o;
   endproperty
   property p_irq_mask;
      !ie_q[IE_STATUS] && !$past(ie_q[IE_STATUS]) |-> !irq_o;
   endproperty
   property p_irq_fire;
      s_match |-> ##[1:3] irq_o;
   endproperty

   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside read cycle");
   a_ie_read: assert property (p_ie_read)
      else $error("irq enable readback wrong");
   a_fc_hold: assert property (p_fc_hold)
      else $error("flow char dropped before ready");
   a_fc_char: assert property (p_fc_char)
      else $error("flow char not programmed value");
   a_load_gap: assert property (p_load_gap)
      else $error("transmit loads back to back");
   a_cts_stop: assert property (p_cts_stop)
      else $error("load while cts held");
   a_irq_mask: assert property (p_irq_mask)
      else $error("irq while masked");
   a_irq_fire: assert property (p_irq_fire)
      else $error("no irq after match");
endmodule

// ===== verification/ubf_serial_peer.sv
module ubf_serial_peer (
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic rst_i,
   // bench commands
   input  wire logic slow_i,
   input  wire logic stop_i,
   // lines toward the block
   output logic      tdr_ready_o,
   output logic      fc_tx_ready_o,
   output logic      cts_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt_q;

   always_ff @(posedge mclk_i) begin
      if (rst_i) cnt_q <= 2'h0;
      else cnt_q <= cnt_q + 2'h1;
   end
   // slow mode accepts one cycle in four
   assign tdr_ready_o   = !rst_i && (!slow_i || cnt_q == 2'h3);
   assign fc_tx_ready_o = !rst_i && (!slow_i || cnt_q == 2'h1);
   assign cts_o         = stop_i;
endmodule

// ===== verification/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import ubf_pkg::*;
   logic        mclk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [15:0] reg_addr_i = 16'h0000;
   logic [7:0]  reg_wdata_i = 8'h00;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [7:0]  rx_byte_i = 8'h00;
   logic        rx_byte_valid_i = 1'b0;
   logic        rx_dma_rd_i = 1'b0;
   logic [7:0]  ubm_wdata_i = 8'h00;
   logic        ubm_wr_i = 1'b0;
   logic        slow = 1'b0;
   logic        stop = 1'b0;
   logic        tdr_ready_i, fc_tx_ready_i, cts_i;
   logic [7:0]  reg_rdata_o, rx_dma_data_o, tdr_data_o, fc_tx_char_o;
   logic        rx_dma_avail_o, ubm_ready_o, tdr_load_o, fc_tx_valid_o;
   logic        rts_o, sample_tick_o, bit_tick_o, irq_o;
   int          error_cnt = 0;
   int          samples_checked = 0;
   int          loads = 0;
   logic        rd_last = 1'b0;
   logic        pop_last = 1'b0;
   logic [7:0]  exp_rd[$], exp_rx[$], exp_tx[$], exp_fc[$];
   logic [15:0] ra[3] = '{ADDR_DIV_HIGH, ADDR_RESUME, ADDR_PAUSE};

   always #25 mclk_i = ~mclk_i;

   ubf_top i_ubf_top (.*);
   ubf_serial_peer i_ubf_serial_peer (.mclk_i(mclk_i), .rst_i(rst_i), .slow_i(slow), .stop_i(stop),
      .tdr_ready_o(tdr_ready_i), .fc_tx_ready_o(fc_tx_ready_i), .cts_o(cts_i));

   ////////////////////////////////////////
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic take(string nm, ref logic [7:0] q[$], input logic [7:0] g);
      if (q.size() == 0) chk(nm, 16'hffff, {8'h00, g});
      else chk(nm, {8'h00, q.pop_front()}, {8'h00, g});
   endtask
   task automatic test_done;
      if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // result watcher
   always @(posedge mclk_i) begin
      rd_last <= reg_rd_i;
      pop_last <= rx_dma_rd_i;
      if (rd_last) take("rdata", exp_rd, reg_rdata_o);
      if (pop_last) take("rxdata", exp_rx, rx_dma_data_o);
      if (tdr_load_o) begin
         loads++;
         take("tdr", exp_tx, tdr_data_o);
      end
      if (fc_tx_valid_o && fc_tx_ready_i) take("fc", exp_fc, fc_tx_char_o);
   end

   ////////////////////////////////////////
   task automatic cyc(int n);
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic wr(logic [15:0] a, logic [7:0] d);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(logic [15:0] a, logic [7:0] e);
      exp_rd.push_back(e);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
   endtask
   task automatic rx(logic [7:0] b, bit keep);
      if (keep) exp_rx.push_back(b);
      @(posedge mclk_i);
      rx_byte_i <= b;
      rx_byte_valid_i <= 1'b1;
      @(posedge mclk_i);
      rx_byte_valid_i <= 1'b0;
   endtask
   task automatic pop(int n);
      repeat (n) begin
         @(posedge mclk_i);
         rx_dma_rd_i <= 1'b1;
         @(posedge mclk_i);
         rx_dma_rd_i <= 1'b0;
      end
   endtask
   // third bit period after the divisor change is clean
   task automatic baud(logic [15:0] d);
      int n, s;
      wr(ADDR_DIV_HIGH, d[15:8]);
      wr(ADDR_DIV_LOW, d[7:0]);
      for (int k = 0; k < 3; k++) begin
         n = 0;
         s = 0;
         @(posedge mclk_i);
         while (!bit_tick_o && n < 4000) begin
            s += int'(sample_tick_o);
            @(posedge mclk_i);
            n++;
         end
      end
      chk("bit_period", 16'(d * 16'd104), 16'(n + 1));
      chk("samples", 16'(OVERSAMPLE), 16'(s + int'(sample_tick_o)));
   endtask

   ////////////////////////////////////////
   initial begin
      int n;
      void'($urandom(4));
      cyc(2);
      rst_i <= 1'b0;
      rd(ADDR_DIV_LOW, RST_DIV_LOW);
      rd(ADDR_DIV_HIGH, RST_DIV_HIGH);
      rd(ADDR_RESUME, RST_RESUME);
      rd(ADDR_PAUSE, RST_PAUSE);
      rd(ADDR_IRQ_EN, 8'h00);
      rd(16'hffb0, 8'h00);
      foreach (ra[i]) begin
         n = $urandom;
         wr(ra[i], n[7:0]);
         rd(ra[i], n[7:0]);
      end
      // random high byte may leave a huge divisor count
      rst_i <= 1'b1;
      cyc(2);
      rst_i <= 1'b0;
      rd(ADDR_DIV_HIGH, RST_DIV_HIGH);
      wr(ADDR_IRQ_EN, 8'hff);
      rd(ADDR_IRQ_EN, 8'h07);
      baud(16'h0001);
      baud(16'h0002);
      baud(16'h0008);
      // match flags and interrupt enable
      wr(ADDR_RESUME, 8'h11);
      wr(ADDR_PAUSE, 8'h13);
      wr(ADDR_IRQ_EN, 8'h00);
      rx(8'h13, 1'b1);
      cyc(3);
      chk("irq", 16'h0, {15'h0, irq_o});
      wr(ADDR_IRQ_EN, 8'h02);
      cyc(2);
      chk("irq", 16'h1, {15'h0, irq_o});
      wr(ADDR_STATUS, 8'h07);
      cyc(2);
      chk("irq", 16'h0, {15'h0, irq_o});
      rx(8'h11, 1'b1);
      cyc(3);
      chk("irq", 16'h1, {15'h0, irq_o});
      pop(2);
      // auto rts marks and hysteresis
      wr(ADDR_FLOW_CTRL, 8'h02);
      for (int i = 1; i <= 12; i++) begin
         rx(8'h80 | 8'($urandom), 1'b1);
         cyc(2);
         chk("rts", {15'h0, i >= 12}, {15'h0, rts_o});
      end
      for (int i = 11; i >= 4; i--) begin
         pop(1);
         cyc(2);
         chk("rts", {15'h0, i > 4}, {15'h0, rts_o});
      end
      for (int i = 0; i < 29; i++) rx(8'h80 | 8'($urandom), i < 28);
      rd(ADDR_RX_LEVEL, 8'h20);
      chk("avail", 16'h1, {15'h0, rx_dma_avail_o});
      pop(32);
      cyc(2);
      chk("rts", 16'h0, {15'h0, rts_o});
      chk("avail", 16'h0, {15'h0, rx_dma_avail_o});
      wr(ADDR_STATUS, 8'h07);
      // xon/xoff receive with a slow sender
      wr(ADDR_MODEM_CTRL, 8'h20);
      wr(ADDR_FLOW_CTRL, 8'h04);
      slow <= 1'b1;
      exp_fc.push_back(8'h13);
      repeat (12) rx(8'h80 | 8'($urandom), 1'b1);
      cyc(10);
      exp_fc.push_back(8'h11);
      pop(8);
      cyc(10);
      chk("fc_left", 16'h0, 16'(exp_fc.size()));
      pop(4);
      slow <= 1'b0;
      // transmit halves, cts hold and xon/xoff pause
      wr(ADDR_DMA_CTRL, 8'h20);
      wr(ADDR_FLOW_CTRL, 8'h09);
      stop <= 1'b1;
      for (int i = 0; i < 32; i++) begin
         n = $urandom;
         exp_tx.push_back(n[7:0]);
         @(posedge mclk_i);
         ubm_wdata_i <= n[7:0];
         ubm_wr_i <= 1'b1;
         @(posedge mclk_i);
         ubm_wr_i <= 1'b0;
      end
      cyc(20);
      chk("loads", 16'h0, 16'(loads));
      chk("ubm_ready", 16'h1, {15'h0, ubm_ready_o});
      rd(ADDR_STATUS, 8'h60);
      stop <= 1'b0;
      cyc(20);
      rx(8'h13, 1'b1);
      cyc(4);
      n = loads;
      cyc(30);
      chk("loads", 16'(n), 16'(loads));
      rx(8'h11, 1'b1);
      cyc(80);
      chk("tx_left", 16'h0, 16'(exp_tx.size()));
      pop(2);
      cyc(4);
      test_done();
   end

   initial begin
      #(20000 * 50);
      error_cnt++;
      test_done();
   end
endmodule

bind ubf_top ubf_top_monitor i_ubf_top_monitor (.*);
